// File: baud_gen.sv
// Purpose: Bit-rate generator with majority-vote receive sampler, APB slave
// Assumes: Inputs synchronous to CLK_I; APB master holds request until PREADY
// Notes:   Every APB access takes one wait state
// Summary of operation
// (R1) One generator serves both asynchronous and synchronous modes.
// (R2) Divisor sets period of a free-running 8-bit timer; its reload is the tick.
// (R3) Asynchronous mode: high-speed select joins divisor in setting rate.
// (R4) Synchronous mode: high-speed select has no effect on rate.
// (R5) Async, low speed: rate is clock over 64 times divisor plus one.
// (R6) Async, high speed: rate is clock over 16 times divisor plus one.
// (R7) Synchronous: rate is clock over 4 times divisor plus one.
// (R8) In sync mode rates apply only as clock master; sync slave gets no ticks.
// (R9) Divisor accepts 0 to 255, each giving a defined rate.
// (R10) Writing the divisor clears the timer at once.
// (R11) Receive line sampled three times per bit, majority decides level.
// (R12) Divisor resets to zero on every reset.
// (R13) Software may prefer high speed even for slow rates for less error.
// (R14) Port enable set routes pins to the serial port; clear disables.
// (R15) One-cycle tick each timer reload; shifters time from it.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module baud_gen (
  input  wire logic                            CLK_I,
  input  wire logic                            RST_N_I,
  input  wire logic                            PSEL_I,
  input  wire logic                            PENABLE_I,
  input  wire logic                            PWRITE_I,
  input  wire logic [baud_gen_pkg::ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]                     PWDATA_I,
  output var  logic [31:0]                     PRDATA_O,
  output var  logic                            PREADY_O,
  output var  logic                            PSLVERR_O,
  input  wire logic                            RX_LINE_I,
  output var  logic                            BIT_TICK_O,
  output var  logic                            RX_BIT_O,
  output var  logic                            PORT_EN_O
);
  import baud_gen_pkg::*;

  logic [1:0]       rst_sync_ff;
  logic             rst_n;
  logic [7:0]       tx_ctrl_ff;
  logic [7:0]       rx_ctrl_ff;
  logic [7:0]       div_ff;
  logic [5:0]       presc_ff;
  logic [7:0]       timer_ff;
  logic [2:0]       rx_samp_ff;
  logic             tick_ff;
  logic             vote_ff;
  logic             port_en_ff;
  logic             pready_ff;
  logic             pslverr_ff;
  logic [31:0]      prdata_ff;
  logic [5:0]       nxt_presc;
  logic [7:0]       nxt_timer;
  logic [7:0]       nxt_tx_ctrl;
  logic [7:0]       nxt_rx_ctrl;
  ctrl_s            ctrl;

  // Reset: asynchronous assert, two-flop release
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // APB decode
  wire acc_phase = PSEL_I && PENABLE_I;
  wire sel_tx    = PADDR_I == OFF_TX_CTRL;
  wire sel_rx    = PADDR_I == OFF_RX_CTRL;
  wire sel_div   = PADDR_I == OFF_DIVISOR;
  wire sel_stat  = PADDR_I == OFF_STATUS;
  wire mapped    = sel_tx || sel_rx || sel_div || sel_stat;
  wire do_write  = acc_phase && pready_ff && PWRITE_I;
  wire tx_wr     = do_write && sel_tx;
  wire rx_wr     = do_write && sel_rx;
  wire div_wr    = do_write && sel_div;
  wire [31:0] rd_data =
      sel_tx   ? {24'h0, tx_ctrl_ff} :
      sel_rx   ? {24'h0, rx_ctrl_ff} :
      sel_div  ? {24'h0, div_ff} :
      sel_stat ? {23'h0, vote_ff, timer_ff} : 32'h0;

  assign nxt_tx_ctrl = (tx_ctrl_ff & ~TX_WMASK) | (PWDATA_I[7:0] & TX_WMASK);
  assign nxt_rx_ctrl = (rx_ctrl_ff & ~RX_WMASK) | (PWDATA_I[7:0] & RX_WMASK);

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= acc_phase && !pready_ff;
      pslverr_ff <= acc_phase && !pready_ff && !mapped;
      prdata_ff  <= (acc_phase && !pready_ff && !PWRITE_I) ? rd_data : 32'h0;
    end
  end

  // Control registers
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      tx_ctrl_ff <= TX_RESET;
      rx_ctrl_ff <= RX_RESET;
      div_ff     <= DIV_RESET; // R12
    end else begin
      if (tx_wr) tx_ctrl_ff <= nxt_tx_ctrl;
      if (rx_wr) rx_ctrl_ff <= nxt_rx_ctrl;
      if (div_wr) div_ff <= PWDATA_I[7:0]; // R9
    end
  end

  // One driver for the whole control bundle
  assign ctrl = '{port_en:    rx_ctrl_ff[RX_PORT_EN_BIT],
                  master:     tx_ctrl_ff[TX_MASTER_BIT],
                  sync:       tx_ctrl_ff[TX_SYNC_BIT],
                  high_speed: tx_ctrl_ff[TX_HS_BIT]};

  // Prescale select: one generator for both modes
  wire [5:0] presc_lim =
      ctrl.sync       ? PRESC_SYNC :     // R1 R4 R7
      ctrl.high_speed ? PRESC_ASYNC_HI : // R3 R6
                        PRESC_ASYNC_LO;  // R5
  // Sync slave takes its clock from outside
  wire gen_run   = ctrl.port_en && (!ctrl.sync || ctrl.master); // R8
  wire presc_end = presc_ff >= presc_lim;
  wire timer_end = timer_ff == div_ff; // R2
  wire raw_tick  = gen_run && presc_end && timer_end; // R15

  assign nxt_presc = (div_wr || !gen_run || presc_end) ? 6'h00 : presc_ff + 6'h01; // R10
  assign nxt_timer = (div_wr || !gen_run) ? 8'h00 : // R10
                     !presc_end ? timer_ff :
                     timer_end  ? 8'h00 : timer_ff + 8'h01; // R2

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      presc_ff <= 6'h00;
      timer_ff <= 8'h00;
      tick_ff  <= 1'b0;
    end else begin
      presc_ff <= nxt_presc;
      timer_ff <= nxt_timer;
      tick_ff  <= raw_tick; // R15
    end
  end

  // Majority of the last three samples of the bit
  wire vote = (rx_samp_ff[0] & rx_samp_ff[1]) | (rx_samp_ff[0] & rx_samp_ff[2]) |
              (rx_samp_ff[1] & rx_samp_ff[2]); // R11

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rx_samp_ff <= 3'h7;
      vote_ff    <= 1'b1;
      port_en_ff <= 1'b0;
    end else begin
      rx_samp_ff <= {rx_samp_ff[1:0], RX_LINE_I}; // R11
      if (raw_tick) vote_ff <= vote; // R11
      port_en_ff <= ctrl.port_en; // R14
    end
  end

  assign PRDATA_O   = prdata_ff;
  assign PREADY_O   = pready_ff;
  assign PSLVERR_O  = pslverr_ff;
  assign BIT_TICK_O = tick_ff;
  assign RX_BIT_O   = vote_ff;
  assign PORT_EN_O  = port_en_ff;

  // Checking helpers: gap between ticks under a steady setup
  logic [GAP_W-1:0] gap_ff;
  logic             clean_ff;
  wire  [7:0]       wr_byte     = PWDATA_I[7:0];
  wire              port_en_cfg = ctrl.port_en;

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff   <= '0;
      clean_ff <= 1'b0;
    end else begin
      gap_ff   <= tick_ff ? GAP_W'(1) : (&gap_ff ? gap_ff : gap_ff + GAP_W'(1));
      clean_ff <= (do_write || !gen_run) ? 1'b0 : (tick_ff ? 1'b1 : clean_ff);
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  a_rate_async_lo: assert property ( // R5
    tick_ff && clean_ff && !ctrl.sync && !ctrl.high_speed |->
      gap_ff == GAP_W'(64) * (GAP_W'(div_ff) + GAP_W'(1)))
    else $error("async low speed period wrong");

  a_rate_async_hi: assert property ( // R6
    tick_ff && clean_ff && !ctrl.sync && ctrl.high_speed |->
      gap_ff == GAP_W'(16) * (GAP_W'(div_ff) + GAP_W'(1)))
    else $error("async high speed period wrong");

  a_rate_sync: assert property ( // R7
    tick_ff && clean_ff && ctrl.sync |-> gap_ff == GAP_W'(4) * (GAP_W'(div_ff) + GAP_W'(1)))
    else $error("sync period wrong");

  a_hs_ignored: assert property ( // R4
    ctrl.sync |-> presc_lim == PRESC_SYNC)
    else $error("high speed select changed sync rate");

  a_hs_async: assert property ( // R3
    !ctrl.sync && $changed(ctrl.high_speed) |-> $changed(presc_lim))
    else $error("high speed select had no effect");

  a_slave_quiet: assert property ( // R8
    !gen_run |=> !tick_ff)
    else $error("tick without master generation");

  a_div_clears: assert property ( // R10
    div_wr |=> timer_ff == 8'h00 && presc_ff == 6'h00 && div_ff == $past(wr_byte))
    else $error("divisor write did not clear timer");

  a_tick_single: assert property ( // R15
    tick_ff |=> !tick_ff ##1 !tick_ff)
    else $error("tick longer than one cycle");

  a_vote_level: assert property ( // R11
    tick_ff |-> vote_ff == $past(vote))
    else $error("voted level wrong");

  a_div_reset: assert property ( // R12
    $rose(rst_n) |-> div_ff == 8'h00)
    else $error("divisor not zero after reset");

  a_port_enable: assert property ( // R14
    PORT_EN_O == $past(port_en_cfg))
    else $error("port enable output mismatch");

  // Bus handshake checks
  a_ready_wait: assert property (
    acc_phase && !pready_ff |=> pready_ff)
    else $error("ready not given after one wait state");

  a_ready_pulse: assert property (
    pready_ff |=> !pready_ff)
    else $error("ready held longer than one cycle");

  a_err_ready: assert property (
    pslverr_ff |-> pready_ff)
    else $error("error response without ready");

  a_unmapped_err: assert property (
    acc_phase && !pready_ff && !mapped |=> pslverr_ff && pready_ff)
    else $error("unmapped access not flagged");

  a_wr_ignored: assert property (
    do_write && !mapped |=> $stable(tx_ctrl_ff) && $stable(rx_ctrl_ff) && $stable(div_ff))
    else $error("unmapped write changed a register");

  a_rdata_idle: assert property (
    !pready_ff |-> prdata_ff == 32'h0)
    else $error("read data not zero outside answer");

  a_rdata_write: assert property (
    acc_phase && !pready_ff && PWRITE_I |=> prdata_ff == 32'h0)
    else $error("read data not zero on write");

  a_rdata_div: assert property ( // R9
    acc_phase && !pready_ff && !PWRITE_I && sel_div |=> prdata_ff == {24'h0, div_ff})
    else $error("divisor read back wrong");

  a_fixed_bits: assert property (
    (tx_ctrl_ff & ~TX_WMASK) == (TX_RESET & ~TX_WMASK) &&
      (rx_ctrl_ff & ~RX_WMASK) == (RX_RESET & ~RX_WMASK))
    else $error("read-only control bits changed");

  // Generator checks
  a_div_hold: assert property ( // R10
    !div_wr |=> $stable(div_ff))
    else $error("divisor changed without a write");

  a_timer_bound: assert property ( // R2
    timer_ff <= div_ff)
    else $error("timer ran past divisor");

  a_idle_cleared: assert property ( // R8
    !gen_run |=> presc_ff == 6'h00 && timer_ff == 8'h00)
    else $error("stopped generator not cleared");

  a_tick_reload: assert property ( // R15
    tick_ff |-> presc_ff == 6'h00 && timer_ff == 8'h00)
    else $error("tick without timer reload");

  a_port_idle: assert property ( // R14
    !ctrl.port_en |=> !tick_ff)
    else $error("tick while port disabled");

  a_vote_hold: assert property ( // R11
    !tick_ff |-> $stable(vote_ff))
    else $error("voted level changed between ticks");

  c_tick_sync:  cover property (tick_ff && clean_ff && ctrl.sync);
  c_tick_hs:    cover property (tick_ff && clean_ff && !ctrl.sync && ctrl.high_speed);
  c_div_write:  cover property (div_wr ##[1:1000] tick_ff);
  c_async_slv:  cover property (tick_ff && !ctrl.sync && !ctrl.master);
  c_unmapped:   cover property (pslverr_ff && pready_ff);

endmodule // baud_gen

`default_nettype wire

// File: baud_gen_pkg.sv
// Purpose: Shared constants and types for the serial bit-rate generator
// Assumes: 32-bit APB register window, one word per register
// Notes:   Register offsets are byte addresses
package baud_gen_pkg;

  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFF_TX_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_RX_CTRL     = 8'h04;
  localparam logic [7:0]  OFF_DIVISOR     = 8'h08;
  localparam logic [7:0]  OFF_STATUS      = 8'h0C;

  localparam logic [7:0]  TX_RESET        = 8'h02;
  localparam logic [7:0]  RX_RESET        = 8'h00;
  localparam logic [7:0]  DIV_RESET       = 8'h00;
  localparam logic [7:0]  TX_WMASK        = 8'hF5;
  localparam logic [7:0]  RX_WMASK        = 8'hF8;

  localparam int          TX_MASTER_BIT   = 7;
  localparam int          TX_SYNC_BIT     = 4;
  localparam int          TX_HS_BIT       = 2;
  localparam int          RX_PORT_EN_BIT  = 7;
  localparam int          STAT_VOTE_BIT   = 8;

  // Prescale limits: divide by 64, 16 and 4
  localparam logic [5:0]  PRESC_ASYNC_LO  = 6'h3F;
  localparam logic [5:0]  PRESC_ASYNC_HI  = 6'h0F;
  localparam logic [5:0]  PRESC_SYNC      = 6'h03;

  localparam int          GAP_W           = 15;

  typedef struct packed {
    logic port_en;
    logic master;
    logic sync;
    logic high_speed;
  } ctrl_s;

endpackage

// File: rx_node_model.sv
// Purpose: Remote serial node driving the receive line
// Assumes: Line level is synchronous to the system clock
// Notes:   Glitch mode inverts the line for one cycle in four
`timescale 1ns/1ns
`default_nettype none

module rx_node_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic level_i,
  input  wire logic glitch_i,
  output var  logic line_o
);
  logic [1:0] phase_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  // Lone minority sample, outvoted by the other two
  assign line_o = level_i ^ (glitch_i & (phase_ff == 2'h0));
endmodule // rx_node_model

`default_nettype wire

// File: test_baud_gen.sv
// Purpose: Self-checking bench for the bit-rate generator
// Assumes: Ticks are counted in rising edges between samples
// Notes:   APB master waits for the ready answer, no fixed latency
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin bad_count++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, g, x); end end

module test_baud_gen;
  import baud_gen_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, tick, rx_bit, port_en, rx_line, e;
  logic        level = 1'b1, glitch = 1'b0;
  int          bad_count = 0, cmp_count = 0, n;
  logic [7:0]  modes [4] = '{8'h80, 8'h84, 8'h90, 8'h94};
  int          presc [4] = '{64, 16, 4, 4};

  always #2 clk = ~clk;

  baud_gen baud_gen_inst (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_LINE_I(rx_line), .BIT_TICK_O(tick),
    .RX_BIT_O(rx_bit), .PORT_EN_O(port_en));

  rx_node_model rx_node_model_inst (.clk_i(clk), .rst_n_i(rst_n), .level_i(level),
    .glitch_i(glitch), .line_o(rx_line));

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask

  task automatic gap(input int lim);
    n = 0;
    do begin @(posedge clk); n++; end while (tick !== 1'b1 && n < lim);
  endtask

  task automatic period(input int p);
    gap(2000);
    gap(2000);
    `CHK(n, p)
  endtask

  task automatic close_out;
    $display("bad_count=%0d cmp_count=%0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFF_TX_CTRL, {24'h0, TX_RESET});
    rd(OFF_DIVISOR, {24'h0, DIV_RESET});
    rd(8'h10, 32'h0);
    `CHK(e, 1'b1)
    wr(OFF_RX_CTRL, 8'h80);
    repeat (2) @(posedge clk);
    `CHK(port_en, 1'b1)
    for (int i = 0; i < 4; i++) begin
      wr(OFF_TX_CTRL, modes[i]);
      wr(OFF_DIVISOR, 8'h02);
      period(presc[i] * 3);
    end
    wr(OFF_TX_CTRL, 8'h04);
    wr(OFF_DIVISOR, 8'h00);
    period(16);
    wr(OFF_TX_CTRL, 8'h10);
    gap(300);
    `CHK(n, 300)
    wr(OFF_TX_CTRL, 8'h90);
    wr(OFF_DIVISOR, 8'hC8);
    repeat (10) @(posedge clk);
    wr(OFF_DIVISOR, 8'h02);
    gap(2000);
    `CHK(n, 13)
    wr(OFF_DIVISOR, 8'hFF);
    rd(OFF_DIVISOR, 32'hFF);
    period(1024);
    wr(OFF_DIVISOR, 8'h00);
    period(4);
    for (int i = 0; i < 3; i++) begin
      level <= (i == 1);
      glitch <= (i > 0);
      repeat (3) gap(100);
      `CHK(rx_bit, (i == 1))
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(q[STAT_VOTE_BIT], (i == 1))
    end
    wr(OFF_RX_CTRL, 8'h00);
    gap(300);
    `CHK(n, 300)
    `CHK(port_en, 1'b0)
    close_out;
  end

  initial begin
    #100000;
    bad_count++;
    close_out;
  end
endmodule // test_baud_gen

`default_nettype wire
